// [relay_signalling_config.sv]
/*
 Switch-configured relay signalling controller with an Avalon-MM register slave.
 Assumes switch pins are asynchronous, event and trip inputs come from bus logic
 on mclk, and a push-button reset drives rst synchronously.
*/
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RL1: Switches are sampled only at start-up after reset, then applied.
// RL2: Enabled self-test steps each of eight relays in turn.
// RL3: Transmit lamp lights at each test step, then flashes with bus activity.
// RL4: Selectable contacts take event A or B from their switch.
// RL5: Without alternatives each contact uses its fixed event, switches ignored.
// RL6: Master role when mode switch selects master, else slave.
// RL7: Local bus runs at 19200 or 38400 bit/s per baud switch.
// RL8: Protection unit must use the same bit rate.
// RL9: Enabled contacts close on their condition and light their lamp.
// RL10: Stand-by never actuates contacts but still drives lamps.
// RL11: Self-test in stand-by steps lamps only, relays stay open.
// RL12: Programming switch on selects programming mode, off normal operation.
// RL13: Manual reset freezes trip signals until a signal reset.
// RL14: Automatic reset clears trip signals when the unit's trip clears.
// RL15: Latch holds every asserted signal until a reset command.
// RL16: Latch mode forces automatic reset off.
// RL17: Self-test lasts about ten seconds, then normal operation resumes.
// RL18: Signal reset returns all relays to rest, contacts open.
// RL19: Sampled settings stay unchanged until the next reset.
module relay_signalling_config
    import relay_cfg_pkg::*;
#(
    parameter int unsigned TEST_LEN  = TEST_CYCLES,
    parameter int unsigned BLINK_LEN = BLINK_CYCLES
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Switch bank pins
    input  wire logic [NSW-1:0]    switch_pins,
    // Protection unit events
    input  wire logic [NRELAY-1:0] event_a,
    input  wire logic [NRELAY-1:0] event_b,
    input  wire logic              trip_in,
    input  wire logic              bus_activity,
    // Outputs to relays, lamps and bus logic
    output logic [NRELAY-1:0]      output_contact,
    output logic [NRELAY-1:0]      contact_led,
    output logic                   txrx_led,
    output logic                   bus_master,
    output logic                   baud_fast,
    output logic                   programming_mode,
    // Avalon-MM slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest
);
    // ------------------------------------------------------------
    // Switch synchroniser
    // ------------------------------------------------------------
    // Three stages; a switch change counts once the last two stages agree.
    logic [NSW-1:0] sw1_q, sw2_q, sw3_q;
    always_ff @(posedge mclk) begin
        sw1_q <= switch_pins;
        sw2_q <= sw1_q;
        sw3_q <= sw2_q;
    end
    wire sw_agree = (sw2_q == sw3_q);

    // ------------------------------------------------------------
    // Start-up sequencer and self-test
    // ------------------------------------------------------------
    state_e             state_q, state_d;
    cfg_s               cfg_q;
    logic [3:0]         boot_q;
    logic [31:0]        tcnt_q;
    logic [2:0]         step_q;
    // Each relay step lasts an eighth of the whole self-test.
    localparam int unsigned STEP_LEN = TEST_LEN / NRELAY;
    // Boot captures when the count hits BOOT_CYCLES with a settled switch bank; otherwise the 4-bit count wraps and comes round again.
    wire boot_done = (boot_q == BOOT_CYCLES) && sw_agree;
    wire step_end  = (tcnt_q == 32'(STEP_LEN - 1));
    wire test_end  = step_end && (step_q == 3'(NRELAY - 1));

    // Self-test runs once after start-up when its switch was captured set.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_BOOT: if (boot_done) state_d = sw3_q[0] ? ST_TEST : ST_RUN;
            ST_TEST: if (test_end) state_d = ST_RUN; // RL17
            ST_RUN:  state_d = ST_RUN;
            default: state_d = ST_BOOT;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_BOOT;
            boot_q  <= '0;
            cfg_q   <= CFG_RST;
            tcnt_q  <= '0;
            step_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_BOOT && !boot_done)
                boot_q <= boot_q + 4'h1;
            if (state_q == ST_BOOT && boot_done)
                cfg_q <= cfg_s'(sw3_q); // RL1 RL19
            if (state_q == ST_TEST) begin
                tcnt_q <= step_end ? '0 : tcnt_q + 32'h1;
                if (step_end)
                    step_q <= step_q + 3'h1; // RL2
            end
        end
    end

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    logic        altok_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    // Every access sees one wait state; read data are latched when the request is first seen.
    // A write takes effect at the edge where waitrequest is low.
    wire req      = avs_read || avs_write;
    wire accept   = req && !wait_q;
    wire wr_ctl   = accept && avs_write && (avs_address == OFS_CONTROL);
    wire sig_rst  = wr_ctl && avs_writedata[CTL_SIGRST];
    // Read data selection; unmapped offsets read as zero.
    wire [31:0] rd_mux =
        (avs_address == OFS_CONFIG)  ? 32'(cfg_q) :
        (avs_address == OFS_CONTROL) ? 32'({altok_q, 1'b0}) :
        (avs_address == OFS_STATUS)  ? {13'h0, state_q, output_contact, contact_led} :
        32'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
            altok_q <= ALTOK_RST;
        end else begin
            wait_q <= !(req && wait_q);
            if (req && wait_q)
                rdata_q <= rd_mux;
            if (wr_ctl)
                altok_q <= avs_writedata[CTL_ALTOK];
        end
    end

    // ------------------------------------------------------------
    // Event selection, freeze, latch
    // ------------------------------------------------------------
    logic [NRELAY-1:0] sig_q, sig_d, ev_sel;
    logic              frozen_q;
    wire auto_eff = cfg_q.auto_reset && !cfg_q.latch; // RL16
    wire running  = (state_q == ST_RUN) && !cfg_q.programming_switch; // RL12

    // Contacts 0 to 3 take event B when alternatives exist and their switch says B.
    always_comb begin
        ev_sel = event_a;
        for (int i = 0; i < NSEL; i++)
            if (altok_q && cfg_q.contact_sel[i]) // RL4 RL5
                ev_sel[i] = event_b[i];
    end

    // Freeze clears on a signal reset, or on trip release under automatic reset.
    wire frz_clr = sig_rst || (auto_eff && !trip_in); // RL13 RL14

    always_comb begin
        if (sig_rst || !running)
            sig_d = '0; // RL18
        else if (frozen_q)
            sig_d = sig_q; // RL13
        else if (cfg_q.latch)
            sig_d = sig_q | ev_sel; // RL15
        else
            sig_d = ev_sel;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sig_q    <= '0;
            frozen_q <= 1'b0;
        end else begin
            sig_q <= sig_d;
            // A trip in the same cycle as a clear keeps the signals frozen.
            if (running && trip_in && !cfg_q.latch)
                frozen_q <= 1'b1;
            else if (frz_clr)
                frozen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Lamps and outputs
    // ------------------------------------------------------------
    // Bus activity restarts the lamp stretch counter.
    logic [31:0] blink_q;
    wire testing = (state_q == ST_TEST);
    wire [NRELAY-1:0] test_vec = NRELAY'(1) << step_q;
    wire [NRELAY-1:0] lamp_d   = testing ? test_vec : sig_d;
    // Stand-by masks the relays only; the lamps still show every switching.
    wire [NRELAY-1:0] relay_d  = cfg_q.standby ? '0 : lamp_d; // RL9 RL10 RL11
    // During self-test the transmit lamp is lit for the first half of each step.
    wire tx_d = testing ? (tcnt_q < 32'(STEP_LEN / 2)) : (blink_q != 32'h0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            output_contact   <= '0;
            contact_led      <= '0;
            txrx_led         <= 1'b0;
            bus_master       <= 1'b0;
            baud_fast        <= 1'b0;
            programming_mode <= 1'b0;
            blink_q          <= '0;
        end else begin
            output_contact   <= relay_d;
            contact_led      <= lamp_d;
            txrx_led         <= tx_d; // RL3
            bus_master       <= cfg_q.master; // RL6
            baud_fast        <= cfg_q.baud_fast; // RL7 RL8
            programming_mode <= cfg_q.programming_switch; // RL12
            if (bus_activity)
                blink_q <= 32'(BLINK_LEN);
            else if (blink_q != 32'h0)
                blink_q <= blink_q - 32'h1;
        end
    end
    // The bus outputs come straight from their registers.
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Checks run only out of reset, all on the system clock.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Start-up, settings and self-test
    // ------------------------------------------------------------
    a_cfg_capture: assert property (state_q == ST_BOOT && boot_done |=> cfg_q == cfg_s'($past(sw3_q))) // RL1
        else $error("settings not captured at start-up");
    a_cfg_held: assert property (state_q == ST_RUN && $past(state_q) == ST_RUN |-> $stable(cfg_q)) // RL19
        else $error("config changed in run");
    a_role_baud: assert property (state_q == ST_RUN ##1 1 // RL6 RL7
        |-> bus_master == cfg_q.master && baud_fast == cfg_q.baud_fast)
        else $error("role or baud mismatch");
    a_programming_switch_pin: assert property (state_q == ST_RUN ##1 1 |-> programming_mode == cfg_q.programming_switch) // RL12
        else $error("programming mode pin mismatch");
    a_test_onehot: assert property (testing && !cfg_q.standby |=> $onehot(output_contact)) // RL2
        else $error("test relay not one-hot");
    a_test_standby_lamps: assert property (testing && cfg_q.standby |=> $onehot(contact_led)) // RL11
        else $error("test lamp not stepping");
    a_test_ends: assert property (test_end |=> state_q == ST_RUN) // RL17
        else $error("self-test did not end");
    a_tx_test: assert property (testing && tcnt_q == '0 |=> txrx_led) // RL3
        else $error("transmit lamp dark at test step");
    a_tx_idle: assert property (state_q == ST_RUN && blink_q == '0 |=> !txrx_led) // RL3
        else $error("transmit lamp lit without bus activity");

    // ------------------------------------------------------------
    // Contacts and lamps
    // ------------------------------------------------------------
    a_standby_no_relay: assert property (cfg_q.standby |=> output_contact == '0) // RL10
        else $error("relay driven in stand-by");
    a_contact_follows: assert property (running && !cfg_q.standby // RL9
        |=> output_contact == $past(sig_d) && contact_led == $past(sig_d))
        else $error("contact or lamp not following its event");
    a_standby_lamps: assert property (running && cfg_q.standby |=> contact_led == $past(sig_d)) // RL10
        else $error("stand-by lamp not following its event");
    a_programming_switch_quiet: assert property (cfg_q.programming_switch && state_q == ST_RUN // RL12
        |=> output_contact == '0 && contact_led == '0)
        else $error("output active in programming mode");
    a_sigreset_opens: assert property (sig_rst && state_q == ST_RUN |=> output_contact == '0) // RL18
        else $error("signal reset left relay closed");

    // ------------------------------------------------------------
    // Freeze and latch
    // ------------------------------------------------------------
    a_frozen_set: assert property (running && trip_in && !cfg_q.latch |=> frozen_q) // RL13
        else $error("trip did not freeze signals");
    a_freeze_stable: assert property (running && frozen_q && !sig_rst |=> sig_q == $past(sig_q)) // RL13
        else $error("frozen signals changed");
    a_auto_clears: assert property (running && auto_eff && frozen_q && !trip_in |=> !frozen_q) // RL14
        else $error("automatic reset did not release freeze");
    a_latch_holds: assert property (running && cfg_q.latch && !sig_rst // RL15
        |=> (sig_q & $past(sig_q)) == $past(sig_q))
        else $error("latched signal dropped");
    a_latch_no_auto: assert property (running && cfg_q.latch && cfg_q.auto_reset && !trip_in && !sig_rst // RL16
        |=> (sig_q & $past(sig_q)) == $past(sig_q))
        else $error("trip clear dropped latched signal");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    // Main scenarios that the bench is expected to reach.
    c_test_done: cover property (testing ##1 state_q == ST_RUN);
    c_standby_test: cover property (testing && cfg_q.standby ##1 state_q == ST_RUN);
    c_trip_frozen: cover property (running && trip_in ##1 frozen_q);
    c_auto_clear: cover property (frozen_q && auto_eff ##1 !frozen_q);
    c_latch_reset: cover property (cfg_q.latch && sig_q != '0 ##1 sig_rst);
endmodule : relay_signalling_config
`default_nettype wire

// [relay_cfg_pkg.sv]
/*
 Constants, types and register map of the relay signalling controller.
 Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
*/
`default_nettype none
package relay_cfg_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TEST_S       = 10;
    localparam int unsigned TEST_CYCLES  = TEST_S * CLK_HZ;
    localparam int unsigned BLINK_MS     = 1;
    localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
    localparam logic [3:0]  BOOT_CYCLES  = 4'h8;
    localparam int unsigned NRELAY       = 8;
    localparam int unsigned NSEL         = 4;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CONFIG  = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_STATUS  = 4'h8;
    localparam int unsigned CTL_SIGRST = 0;
    localparam int unsigned CTL_ALTOK  = 1;
    localparam logic        ALTOK_RST  = 1'b1;
    localparam int unsigned NSW        = 13;

    // Sampled switch bank, one field per switch group.
    typedef struct packed {
        logic            spare;
        logic            term;
        logic            latch;
        logic            auto_reset;
        logic            programming_switch;
        logic            standby;
        logic            baud_fast;
        logic            master;
        logic [NSEL-1:0] contact_sel;
        logic            self_test;
    } cfg_s;

    localparam cfg_s CFG_RST = '0;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_TEST = 3'b010,
        ST_RUN  = 3'b100
    } state_e;
endpackage : relay_cfg_pkg
`default_nettype wire

// [prot_unit_model.sv]
/*
 Protection unit model: event levels, trip indication and bus chatter.
 Assumes the bench sets the wanted levels on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module prot_unit_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] a_set,
    input  wire logic [7:0] b_set,
    input  wire logic       trip_set,
    input  wire logic       chat,
    input  wire logic       baud_fast,
    output logic [7:0]      event_a,
    output logic [7:0]      event_b,
    output logic            trip_in,
    output logic            bus_activity
);
    int cnt;
    always_ff @(posedge mclk) begin
        event_a      <= a_set;
        event_b      <= b_set;
        trip_in      <= trip_set;
        cnt          <= (rst || cnt == 0) ? (baud_fast ? 20 : 40) : cnt - 1;
        bus_activity <= chat && !rst && cnt == 0;
    end
endmodule : prot_unit_model
`default_nettype wire

// [tb_relay_signalling_config.sv]
/*
 Self-checking bench of the relay signalling controller.
 Assumes prot_unit_model stands on the event side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_relay_signalling_config
    import relay_cfg_pkg::*;
;
    logic mclk = 0, rst = 1, trip_set = 0, chat = 0, rd = 0, wr = 0, alt = 1, lt = 0;
    logic [NSW-1:0] sw = 0, cs = 0;
    logic [7:0] a_set = 0, b_set = 0, lc = 0, ll = 0, seqc[$], seql[$];
    logic [3:0] adr = 0;
    logic [31:0] wd = 0, q;
    wire logic [7:0] ev_a, ev_b, oc, led;
    wire logic trip, act, txrx, bm, bf, pm, wt;
    wire logic [31:0] rdat;
    int err_total = 0, comparisons = 0, seed = 80, cyc = 0, rises = 0;

    initial forever #50 mclk = ~mclk;

    prot_unit_model prot_unit_model_inst (.mclk(mclk), .rst(rst), .a_set(a_set), .b_set(b_set),
        .trip_set(trip_set), .chat(chat), .baud_fast(bf), .event_a(ev_a), .event_b(ev_b),
        .trip_in(trip), .bus_activity(act));
    relay_signalling_config #(.TEST_LEN(800), .BLINK_LEN(5)) relay_signalling_config_inst (
        .mclk(mclk), .rst(rst), .switch_pins(sw), .event_a(ev_a), .event_b(ev_b),
        .trip_in(trip), .bus_activity(act), .output_contact(oc), .contact_led(led),
        .txrx_led(txrx), .bus_master(bm), .baud_fast(bf), .programming_mode(pm),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wt));

    task end_of_test;
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Each new nonzero relay or lamp pattern is logged to follow the self-test steps.
    always @(posedge mclk) begin
        if (oc !== lc && oc != 0) seqc.push_back(oc);
        if (led !== ll && led != 0) seql.push_back(led);
        if (txrx === 1'b1 && lt !== 1'b1) rises++;
        lc = oc;
        ll = led;
        lt = txrx;
        if (++cyc > 20000) begin
            err_total++;
            end_of_test;
        end
    end

    task chk_out(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do
            @(posedge mclk);
        while (wt !== 1'b0);
        q = rdat;
        rd <= 0;
        wr <= 0;
    endtask : bus

    task boot(input logic [NSW-1:0] s);
        sw <= s;
        cs = s;
        alt = 1;
        a_set <= 0;
        trip_set <= 0;
        rst <= 1;
        repeat (3) @(posedge mclk);
        rst <= 0;
        seqc.delete();
        seql.delete();
        rises = 0;
        repeat (24) @(posedge mclk);
    endtask : boot

    task step(input logic [7:0] a, input logic [7:0] b, input logic t);
        trip_set <= t;
        repeat (3) @(posedge mclk);
        a_set <= a;
        b_set <= b;
        repeat (4) @(posedge mclk);
    endtask : step

    function automatic logic [7:0] f(input logic [7:0] a, input logic [7:0] b);
        f = a;
        for (int i = 0; i < 4; i++) if (alt && cs[i+1]) f[i] = b[i];
    endfunction : f

    task chk_io(input logic [7:0] e);
        chk_out(oc, (cs[7] | cs[8]) ? 8'h00 : e);
        chk_out(led, cs[8] ? 8'h00 : e);
    endtask : chk_io

    task rnd(input int n);
        logic [31:0] r;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            step(r[7:0], r[15:8], 0);
            chk_io(f(r[7:0], r[15:8]));
        end
    endtask : rnd

    task test_seq(input int nc);
        repeat (900) @(posedge mclk);
        chk_reg(seqc.size(), nc);
        chk_reg(seql.size(), 8);
        for (int i = 0; i < 8; i++) chk_out(seql[i], 8'h01 << i);
        for (int i = 0; i < nc; i++) chk_out(seqc[i], 8'h01 << i);
        chk_reg(rises, 8);
    endtask : test_seq

    initial begin
        boot(13'h006a);
        chk_reg({31'h0, bm}, 32'h1);
        chk_reg({31'h0, bf}, 32'h1);
        bus(0, OFS_CONTROL, 0);
        chk_reg(q, 32'h2);
        bus(0, OFS_CONFIG, 0);
        chk_reg(q, 32'h6a);
        bus(0, 4'hc, 0);
        chk_reg(q, 32'h0);
        sw <= 13'h1fff;
        rnd(4);
        bus(1, OFS_CONFIG, 32'hffff);
        bus(0, OFS_CONFIG, 0);
        chk_reg(q, 32'h6a);
        chk_reg({bm, bf, pm}, 3'h6);
        bus(1, OFS_CONTROL, 0);
        alt = 0;
        rnd(4);
        bus(0, OFS_STATUS, 0);
        chk_reg(q, {13'h0, 3'h4, f(a_set, b_set), f(a_set, b_set)});
        rises = 0;
        chat <= 1;
        repeat (100) @(posedge mclk);
        chat <= 0;
        chk_reg(rises > 1, 1);
        boot(13'h0000);
        step(8'h5a, 0, 0);
        step(8'h0f, 0, 1);
        step(8'h0f, 0, 0);
        chk_io(8'h5a);
        bus(1, OFS_CONTROL, 32'h3);
        step(8'h0f, 0, 0);
        chk_io(8'h0f);
        boot(13'h0200);
        step(8'h5a, 0, 0);
        step(8'h0f, 0, 1);
        chk_io(8'h5a);
        step(8'h0f, 0, 0);
        chk_io(8'h0f);
        boot(13'h0600);
        step(8'h81, 0, 0);
        step(8'h10, 0, 1);
        step(8'h00, 0, 0);
        chk_io(8'h91);
        bus(1, OFS_CONTROL, 32'h3);
        repeat (3) @(posedge mclk);
        chk_io(8'h00);
        boot(13'h0080);
        rnd(4);
        boot(13'h0100);
        chk_reg({31'h0, pm}, 32'h1);
        rnd(2);
        boot(13'h0001);
        test_seq(8);
        boot(13'h0081);
        test_seq(0);
        end_of_test;
    end
endmodule : tb_relay_signalling_config
`default_nettype wire
